// >>> inc/watchdog_pkg.sv
/*
 * Constants for the windowed watchdog register block: register indices,
 * field positions, reset values, magic words and bus-clock counts.
 * Assumes a Wishbone slave on 32-bit data with byte address = 4 * index.
 */
`default_nettype none

package watchdog_pkg;
    // =====================================================================
    // register indices (byte address is four times the index)
    localparam logic [13:0] IDX_CS1 = 14'h3030;
    localparam logic [13:0] IDX_CS2 = 14'h3031;
    localparam logic [13:0] IDX_CNTH = 14'h3032;
    localparam logic [13:0] IDX_CNTL = 14'h3033;
    localparam logic [13:0] IDX_TOVH = 14'h3034;
    localparam logic [13:0] IDX_TOVL = 14'h3035;
    localparam logic [13:0] IDX_WINH = 14'h3036;
    localparam logic [13:0] IDX_WINL = 14'h3037;

    // =====================================================================
    // field positions
    localparam int CS1_EN_BIT = 7;
    localparam int CS1_INT_BIT = 6;
    localparam int CS1_UPD_BIT = 5;
    localparam int CS2_WIN_BIT = 7;
    localparam int CS2_FLAG_BIT = 6;
    localparam int CS2_DIV_BIT = 4;
    localparam int CS2_CLK_LSB = 0;

    // write-once lock bits, one per configuration register
    localparam int LOCK_CS1 = 0;
    localparam int LOCK_CS2 = 1;
    localparam int LOCK_TOVH = 2;
    localparam int LOCK_TOVL = 3;
    localparam int LOCK_WINH = 4;
    localparam int LOCK_WINL = 5;

    // =====================================================================
    // reset values
    localparam logic [7:0] CS1_RESET = 8'h80;
    localparam logic [1:0] CLK_RESET = 2'h1;
    localparam logic [15:0] TOVAL_RESET = 16'h0004;
    localparam logic [15:0] WIN_RESET = 16'h0000;

    // =====================================================================
    // magic words and counter clock sources
    localparam logic [15:0] REFRESH_FIRST = 16'hA602;
    localparam logic [15:0] REFRESH_SECOND = 16'hB480;
    localparam logic [15:0] UNLOCK_FIRST = 16'hC520;
    localparam logic [15:0] UNLOCK_SECOND = 16'hD928;
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_LPO = 2'h1;
    localparam logic [1:0] SRC_IRC = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;

    // =====================================================================
    // timing, in bus clocks; prescaler ratio in source ticks
    localparam int SEQ_GAP_CLKS = 16;
    localparam int RECONFIG_CLKS = 128;
    localparam int RESET_DELAY_CLKS = 128;
    localparam int PRESCALE_DIV = 256;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_FIRST_HI = 2'b01,
        SEQ_WAIT = 2'b10,
        SEQ_SECOND_HI = 2'b11
    } seq_state_e;
endpackage

`default_nettype wire

// >>> hdl/windowed_watchdog_regs.sv
/*
 * Windowed watchdog: control/status registers, counter with selectable
 * and prescaled source, refresh/unlock sequence checker and reset path.
 * Assumes a classic Wishbone master, source ticks as one-cycle pulses
 * synchronous to clk_i, and a system reset that asserts rst_i in return.
 */
// What this block does and what software must do
// RULE1: window enable bit is write-once
// RULE2: flag set on interrupt, write one clears
// RULE3: reserved bits read as zero
// RULE4: prescaler bit divides reference by 256
// RULE5: two-bit field selects counter source
// RULE6: counter bytes readable at any time
// RULE7: counter writes never load the counter
// RULE8: valid refresh clears counter to zero
// RULE9: unlock with permit reopens configuration
// RULE10: stray counter write forces reset
// RULE11: counter reaching timeout forces reset
// RULE12: software never programs timeout zero
// RULE13: window value sets earliest valid refresh
// RULE14: software keeps window below timeout
// RULE15: high byte at lower address
// RULE16: refresh words within 16 clocks
// RULE17: unlock words, reconfigure within 128 clocks
// RULE18: interrupt option delays reset 128 clocks
// RULE19: early refresh in window mode resets
// RULE20: counter counts ticks; flag set per event
`timescale 1ns/1ns
`default_nettype none

module windowed_watchdog_regs (
    input wire logic clk_i, // bus clock, 25 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [15:0] adr_i, // wishbone byte address
    input wire logic [3:0] sel_i, // wishbone byte selects
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o, // wishbone acknowledge
    input wire logic lpo_tick_i, // ~1 kHz source tick
    input wire logic irc_tick_i, // 32 kHz source tick
    input wire logic ext_tick_i, // external source tick
    output logic irq_o, // interrupt request, level
    output logic sys_reset_o // forced system reset, level
);
    import watchdog_pkg::*;

    // =====================================================================
    // bus slave
    logic ack_q;
    logic [31:0] dat_q;
    wire req_w = cyc_i & stb_i & ~ack_q;
    wire wr_w = req_w & we_i & sel_i[0];
    wire [13:0] idx_w = adr_i[15:2];
    wire [7:0] wbyte_w = dat_i[7:0];

    function automatic logic hit(input logic [13:0] idx, input logic [13:0] reg_idx);
        return idx == reg_idx;
    endfunction

    wire wr_cs1_w = wr_w & hit(idx_w, IDX_CS1);
    wire wr_cs2_w = wr_w & hit(idx_w, IDX_CS2);
    wire wr_cnth_w = wr_w & hit(idx_w, IDX_CNTH); // RULE15
    wire wr_cntl_w = wr_w & hit(idx_w, IDX_CNTL);
    wire wr_tovh_w = wr_w & hit(idx_w, IDX_TOVH);
    wire wr_tovl_w = wr_w & hit(idx_w, IDX_TOVL);
    wire wr_winh_w = wr_w & hit(idx_w, IDX_WINH);
    wire wr_winl_w = wr_w & hit(idx_w, IDX_WINL);

    // =====================================================================
    // configuration state
    logic [7:0] cs1_q;
    logic win_en_q, flag_q, div_q;
    logic [1:0] clk_sel_q;
    logic [15:0] toval_q, win_q, count_q;
    logic [5:0] written_q;
    logic open_q;
    logic [6:0] open_cnt_q;
    wire en_w = cs1_q[CS1_EN_BIT];
    wire int_w = cs1_q[CS1_INT_BIT];
    wire upd_w = cs1_q[CS1_UPD_BIT];
    wire [5:0] ok_w = ~written_q | {6{open_q}};

    wire [7:0] cs2_rd_w = {win_en_q, flag_q, 1'b0, div_q, 2'b00, clk_sel_q}; // RULE3
    wire [7:0] rd_byte_w =
        hit(idx_w, IDX_CS1) ? cs1_q :
        hit(idx_w, IDX_CS2) ? cs2_rd_w :
        hit(idx_w, IDX_CNTH) ? count_q[15:8] : // RULE6
        hit(idx_w, IDX_CNTL) ? count_q[7:0] :
        hit(idx_w, IDX_TOVH) ? toval_q[15:8] :
        hit(idx_w, IDX_TOVL) ? toval_q[7:0] :
        hit(idx_w, IDX_WINH) ? win_q[15:8] :
        hit(idx_w, IDX_WINL) ? win_q[7:0] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req_w;
            dat_q <= (req_w & ~we_i) ? {24'h000000, rd_byte_w} : 32'h00000000;
        end
    end

    // =====================================================================
    // counter clock: source select and fixed prescaler
    logic [7:0] div_cnt_q;
    wire src_tick_w = (clk_sel_q == SRC_BUS) ? 1'b1 : // RULE5
                      (clk_sel_q == SRC_LPO) ? lpo_tick_i :
                      (clk_sel_q == SRC_IRC) ? irc_tick_i : ext_tick_i;
    wire div_wrap_w = div_cnt_q == 8'(PRESCALE_DIV - 1);
    wire tick_w = src_tick_w & (~div_q | div_wrap_w); // RULE4

    // =====================================================================
    // refresh / unlock sequence checker
    seq_state_e seq_q, seq_d;
    logic [7:0] hi_q;
    logic unlock_q;
    logic [4:0] gap_cnt_q;
    logic illegal_w, refresh_done_w, unlock_done_w, first_done_w, early_w;
    wire [15:0] word_w = {hi_q, wbyte_w};
    wire [15:0] second_w = unlock_q ? UNLOCK_SECOND : REFRESH_SECOND;
    wire waiting_w = (seq_q == SEQ_WAIT) | (seq_q == SEQ_SECOND_HI);
    wire second_ok_w = (seq_q == SEQ_SECOND_HI) & wr_cntl_w & (word_w == second_w);
    wire gap_expired_w = waiting_w & ~second_ok_w
                         & (gap_cnt_q == 5'(SEQ_GAP_CLKS - 1)); // RULE16

    always_comb begin
        seq_d = seq_q;
        illegal_w = 1'b0;
        first_done_w = 1'b0;
        unique case (seq_q)
            SEQ_IDLE: begin
                if (wr_cnth_w & ((wbyte_w == REFRESH_FIRST[15:8])
                                 | (wbyte_w == UNLOCK_FIRST[15:8]))) begin
                    seq_d = SEQ_FIRST_HI;
                end else if (wr_cnth_w | wr_cntl_w) begin
                    illegal_w = 1'b1; // RULE10
                end
            end
            SEQ_FIRST_HI: begin
                if (wr_cntl_w & ((word_w == REFRESH_FIRST) | (word_w == UNLOCK_FIRST))) begin
                    seq_d = SEQ_WAIT;
                    first_done_w = 1'b1;
                end else if (wr_cnth_w | wr_cntl_w) begin
                    seq_d = SEQ_IDLE;
                    illegal_w = 1'b1;
                end
            end
            SEQ_WAIT: begin
                if (wr_cnth_w & ~gap_expired_w & (wbyte_w == second_w[15:8])) begin
                    seq_d = SEQ_SECOND_HI;
                end else if (wr_cnth_w | wr_cntl_w | gap_expired_w) begin
                    seq_d = SEQ_IDLE;
                    illegal_w = wr_cnth_w | wr_cntl_w;
                end
            end
            SEQ_SECOND_HI: begin
                if (wr_cnth_w | wr_cntl_w | gap_expired_w) begin
                    seq_d = SEQ_IDLE;
                    illegal_w = (wr_cnth_w | wr_cntl_w) & ~second_ok_w;
                end
            end
        endcase
    end

    assign refresh_done_w = second_ok_w & ~unlock_q; // RULE8
    assign unlock_done_w = second_ok_w & unlock_q;
    // refresh judged early by the counter at the first word
    assign early_w = first_done_w & (word_w == REFRESH_FIRST) & win_en_q
                     & (count_q < win_q); // RULE13 RULE19

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_q <= SEQ_IDLE;
            hi_q <= 8'h00;
            unlock_q <= 1'b0;
            gap_cnt_q <= 5'h00;
        end else begin
            seq_q <= seq_d;
            if (wr_cnth_w) begin
                hi_q <= wbyte_w;
            end
            if (first_done_w) begin
                unlock_q <= word_w == UNLOCK_FIRST;
            end
            gap_cnt_q <= waiting_w ? gap_cnt_q + 5'h01 : 5'h00;
        end
    end

    // =====================================================================
    // reset-triggering events and the delayed reset path
    logic alarm_q, alarm_delayed_q;
    logic [6:0] delay_cnt_q;
    logic irq_q, sys_reset_q;
    wire timeout_w = en_w & (count_q == toval_q); // RULE11
    wire reconfig_expired_w = open_q & ~wr_cs1_w
                              & (open_cnt_q == 7'(RECONFIG_CLKS - 1)); // RULE17
    wire unlock_denied_w = unlock_done_w & ~upd_w;
    wire event_w = ~alarm_q & (illegal_w | gap_expired_w | early_w | timeout_w
                               | reconfig_expired_w | unlock_denied_w);
    wire flag_set_w = event_w & int_w; // RULE20
    // a new event wins over a same-cycle write-one-clear
    wire flag_d = flag_set_w | (flag_q & ~(wr_cs2_w & wbyte_w[CS2_FLAG_BIT])); // RULE2
    wire delay_done_w = alarm_q & alarm_delayed_q
                        & (delay_cnt_q == 7'(RESET_DELAY_CLKS - 1)); // RULE18

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_q <= 1'b0;
            alarm_delayed_q <= 1'b0;
            delay_cnt_q <= 7'h00;
            irq_q <= 1'b0;
            sys_reset_q <= 1'b0;
        end else begin
            if (event_w) begin
                alarm_q <= 1'b1;
                alarm_delayed_q <= int_w;
            end
            delay_cnt_q <= alarm_q ? delay_cnt_q + 7'h01 : 7'h00;
            irq_q <= flag_d & int_w;
            if ((event_w & ~int_w) | delay_done_w) begin
                sys_reset_q <= 1'b1; // RULE18
            end
        end
    end

    // =====================================================================
    // counter and configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_q <= 8'h00;
            count_q <= 16'h0000;
        end else begin
            if (src_tick_w) begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
            // counter bytes are never loaded from the bus
            if (refresh_done_w) begin
                count_q <= 16'h0000; // RULE7
            end else if (tick_w & en_w) begin
                count_q <= count_q + 16'h0001; // RULE20
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs1_q <= CS1_RESET;
            win_en_q <= 1'b0;
            flag_q <= 1'b0;
            div_q <= 1'b0;
            clk_sel_q <= CLK_RESET;
            toval_q <= TOVAL_RESET;
            win_q <= WIN_RESET;
            written_q <= 6'h00;
            open_q <= 1'b0;
            open_cnt_q <= 7'h00;
        end else begin
            flag_q <= flag_d;
            if (wr_cs1_w & ok_w[LOCK_CS1]) begin
                cs1_q <= wbyte_w & 8'hE0;
            end
            if (wr_cs2_w & ok_w[LOCK_CS2]) begin
                win_en_q <= wbyte_w[CS2_WIN_BIT]; // RULE1
                div_q <= wbyte_w[CS2_DIV_BIT];
                clk_sel_q <= wbyte_w[CS2_CLK_LSB +: 2];
            end
            if (wr_tovh_w & ok_w[LOCK_TOVH]) begin
                toval_q[15:8] <= wbyte_w;
            end
            if (wr_tovl_w & ok_w[LOCK_TOVL]) begin
                toval_q[7:0] <= wbyte_w;
            end
            if (wr_winh_w & ok_w[LOCK_WINH]) begin
                win_q[15:8] <= wbyte_w;
            end
            if (wr_winl_w & ok_w[LOCK_WINL]) begin
                win_q[7:0] <= wbyte_w;
            end
            if (unlock_done_w & upd_w) begin
                written_q <= 6'h00; // RULE9
                open_q <= 1'b1;
                open_cnt_q <= 7'h00;
            end else begin
                written_q <= written_q | {wr_winl_w, wr_winh_w, wr_tovl_w, wr_tovh_w,
                                          wr_cs2_w, wr_cs1_w};
                open_cnt_q <= open_q ? open_cnt_q + 7'h01 : 7'h00;
                // the control write ends the reconfiguration window
                if (wr_cs1_w | reconfig_expired_w) begin
                    open_q <= 1'b0;
                end
            end
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign irq_o = irq_q;
    assign sys_reset_o = sys_reset_q;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RESERVED_ZERO: assert property (req_w & ~we_i & hit(idx_w, IDX_CS2) |=> // RULE3
        ack_o && dat_o[5] == 1'b0 && dat_o[3:2] == 2'b00) else $error("reserved bits nonzero");
    AST_COUNT_READ: assert property (req_w & ~we_i & hit(idx_w, IDX_CNTH) |=> // RULE6
        dat_o[7:0] == $past(count_q[15:8])) else $error("counter read mismatch");
    AST_REFRESH_CLEAR: assert property (refresh_done_w |=> count_q == 16'h0000) // RULE8
        else $error("refresh did not clear counter");
    AST_NO_LOAD: assert property (wr_cntl_w & ~refresh_done_w |=> // RULE7
        count_q == $past(count_q) || count_q == $past(count_q) + 16'h0001)
        else $error("counter loaded by write");
    AST_ILLEGAL_RESET: assert property (illegal_w & ~alarm_q & ~int_w |=> sys_reset_o) // RULE10
        else $error("illegal write gave no reset");
    AST_TIMEOUT_RESET: assert property (timeout_w & ~alarm_q & ~int_w |=> sys_reset_o) // RULE11
        else $error("timeout gave no reset");
    AST_RESET_DELAY: assert property ($rose(alarm_q) && alarm_delayed_q |-> // RULE18
        ##127 !sys_reset_o ##1 sys_reset_o) else $error("delayed reset off by cycles");
    AST_FLAG_SET: assert property (flag_set_w |=> flag_q && irq_o) // RULE2
        else $error("flag not set on event");
    AST_GAP_RESET: assert property (gap_expired_w & ~alarm_q |=> alarm_q) // RULE16
        else $error("slow sequence not caught");
    AST_EARLY_REFRESH: assert property (early_w & ~alarm_q |=> alarm_q) // RULE19
        else $error("early refresh not caught");
    AST_UNLOCK_OPEN: assert property (unlock_done_w & upd_w |=> open_q && written_q == 6'h00) // RULE9
        else $error("unlock did not reopen");
    AST_WIN_ONCE: assert property (wr_cs2_w & written_q[LOCK_CS2] & ~open_q |=> // RULE1
        $stable(win_en_q)) else $error("window bit rewritten");

    COV_REFRESH: cover property (refresh_done_w);
    COV_UNLOCK: cover property (unlock_done_w & upd_w ##[1:128] wr_cs1_w);
    COV_DELAYED_RESET: cover property ($rose(alarm_q) && alarm_delayed_q ##[1:200] sys_reset_o);
endmodule // windowed_watchdog_regs

`default_nettype wire

// >>> testbench/windowed_watchdog_regs_bench.sv
/*
 * Self-checking bench for the windowed watchdog register block.
 * Assumes the watchdog package is compiled first; the bench drives the
 * Wishbone port and the three source tick inputs itself.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end

module windowed_watchdog_regs_bench;
    import watchdog_pkg::*;

    logic clk_i, rst_i, cyc_i, stb_i, we_i;
    logic [15:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic ack_o, lpo_tick_i, irc_tick_i, ext_tick_i, irq_o, sys_reset_o;
    int errors = 0;
    int tests_run = 0;

    windowed_watchdog_regs uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .lpo_tick_i(lpo_tick_i), .irc_tick_i(irc_tick_i), .ext_tick_i(ext_tick_i),
        .irq_o(irq_o), .sys_reset_o(sys_reset_o)
    );

    // =====================================================================
    // clock, bus and tick tasks
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; returns at the edge after release
    task automatic xfer(input logic wr, input logic [13:0] idx, input logic [7:0] v,
                        output logic [31:0] rdata);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'hF;
        dat_i <= {24'h0, v};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rdata = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] v);
        logic [31:0] d;
        xfer(1'b1, idx, v, d);
    endtask

    task automatic rdchk(input logic [13:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        xfer(1'b0, idx, 8'h00, d);
        `CHK(d, {24'h0, exp})
    endtask

    // a 16-bit word goes to the counter pair, upper byte first
    task automatic word(input logic [15:0] w);
        wr(IDX_CNTH, w[15:8]);
        wr(IDX_CNTL, w[7:0]);
    endtask

    // which: 0 low-power, 1 internal, 2 external; ticks spaced two cycles
    task automatic tick(input int which, input int n);
        repeat (n) begin
            lpo_tick_i <= (which == 0);
            irc_tick_i <= (which == 1);
            ext_tick_i <= (which == 2);
            @(posedge clk_i);
            lpo_tick_i <= 1'b0;
            irc_tick_i <= 1'b0;
            ext_tick_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        cycles(8);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic done(input string name);
        $display("test %s done, errors so far %0d", name, errors);
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =====================================================================
    // watchdog of the bench: the whole run needs far fewer cycles
    initial begin
        cycles(20000);
        errors++;
        complete_run();
    end

    // =====================================================================
    // tests
    initial begin
        {rst_i, cyc_i, stb_i, we_i, lpo_tick_i, irc_tick_i, ext_tick_i} = 7'h40;
        adr_i = 16'h0;
        sel_i = 4'h0;
        dat_i = 32'h0;
        do_reset();

        rdchk(IDX_CS1, CS1_RESET);
        rdchk(IDX_CS2, 8'h01);
        rdchk(IDX_CNTH, 8'h00);
        rdchk(IDX_TOVL, TOVAL_RESET[7:0]);
        rdchk(14'h3038, 8'h00);
        wr(IDX_CS2, 8'hFF);
        rdchk(IDX_CS2, 8'h93);
        wr(IDX_CS2, 8'h00);
        rdchk(IDX_CS2, 8'h93);
        done("reset_values");

        // prescaled internal source; other sources must not move it
        do_reset();
        wr(IDX_TOVH, 8'hFF);
        wr(IDX_TOVL, 8'hFF);
        wr(IDX_CS2, 8'h12);
        tick(1, 255);
        tick(0, 3);
        tick(2, 3);
        rdchk(IDX_CNTL, 8'h00);
        tick(1, 1);
        rdchk(IDX_CNTL, 8'h01);
        done("prescaler");

        // refresh, then a stray counter write
        do_reset();
        wr(IDX_TOVH, 8'hFF);
        wr(IDX_TOVL, 8'hFF);
        wr(IDX_CS2, 8'h03);
        tick(2, 5);
        rdchk(IDX_CNTL, 8'h05);
        rdchk(IDX_CNTH, 8'h00);
        word(REFRESH_FIRST);
        word(REFRESH_SECOND);
        rdchk(IDX_CNTL, 8'h00);
        `CHK(sys_reset_o, 1'b0)
        wr(IDX_CNTL, 8'h05);
        cycles(2);
        `CHK(sys_reset_o, 1'b1)
        rdchk(IDX_CNTL, 8'h00);
        done("refresh");

        // second word never sent within 16 clocks
        do_reset();
        word(REFRESH_FIRST);
        cycles(20);
        `CHK(sys_reset_o, 1'b1)
        done("slow_refresh");

        // timeout compare at the reset value of the limit
        do_reset();
        tick(0, 3);
        cycles(2);
        `CHK(sys_reset_o, 1'b0)
        tick(0, 1);
        cycles(2);
        `CHK(sys_reset_o, 1'b1)
        done("timeout");

        // interrupt option delays the reset by 128 cycles
        do_reset();
        wr(IDX_CS1, 8'hC0);
        wr(IDX_CNTL, 8'h11);
        rdchk(IDX_CS2, 8'h41);
        `CHK(irq_o, 1'b1)
        // keep the low-power source while clearing the flag
        wr(IDX_CS2, 8'h41);
        rdchk(IDX_CS2, 8'h01);
        `CHK(irq_o, 1'b0)
        cycles(80);
        `CHK(sys_reset_o, 1'b0)
        cycles(60);
        `CHK(sys_reset_o, 1'b1)
        done("irq_delay");

        // window mode: refresh at the window value passes, below it fails
        do_reset();
        wr(IDX_TOVH, 8'hFF);
        wr(IDX_TOVL, 8'hFF);
        wr(IDX_WINH, 8'h00);
        wr(IDX_WINL, 8'h10);
        wr(IDX_CS2, 8'h83);
        tick(2, 16);
        word(REFRESH_FIRST);
        word(REFRESH_SECOND);
        `CHK(sys_reset_o, 1'b0)
        rdchk(IDX_CNTL, 8'h00);
        word(REFRESH_FIRST);
        word(REFRESH_SECOND);
        cycles(2);
        `CHK(sys_reset_o, 1'b1)
        done("window");

        // unlock with permit set reopens the write-once registers
        do_reset();
        wr(IDX_CS1, 8'hA0);
        wr(IDX_TOVH, 8'h01);
        wr(IDX_TOVL, 8'h00);
        wr(IDX_TOVL, 8'h33);
        rdchk(IDX_TOVL, 8'h00);
        word(UNLOCK_FIRST);
        word(UNLOCK_SECOND);
        wr(IDX_TOVL, 8'h20);
        rdchk(IDX_TOVL, 8'h20);
        wr(IDX_CS1, 8'hA0);
        cycles(140);
        `CHK(sys_reset_o, 1'b0)
        done("unlock");

        // unlock without a following configuration write expires
        do_reset();
        wr(IDX_CS1, 8'hA0);
        word(UNLOCK_FIRST);
        word(UNLOCK_SECOND);
        cycles(140);
        `CHK(sys_reset_o, 1'b1)
        done("unlock_expiry");

        // bus clock source; unlock refused while the permit bit is clear
        do_reset();
        wr(IDX_TOVH, 8'hFF);
        wr(IDX_TOVL, 8'hFF);
        wr(IDX_CS2, 8'h00);
        rdchk(IDX_CNTL, 8'h02);
        word(UNLOCK_FIRST);
        word(UNLOCK_SECOND);
        cycles(2);
        `CHK(sys_reset_o, 1'b1)
        done("unlock_denied");

        complete_run();
    end
endmodule // windowed_watchdog_regs_bench

`default_nettype wire
